// >>> host_data_fifo_control.v
`timescale 1ns/1ps
`include "host_data_fifo_defs.vh"
module host_data_fifo_control #(
	parameter BUF_DEPTH = 512,
	parameter BUF_AW = 9,
	parameter CNT_W = 10,
	parameter STAGE_DEPTH = 32,
	parameter STAGE_AW = 5
) (
	input wire sys_clk, // System clock, 200 MHz
	input wire rst, // Synchronous reset, active high
	input wire addr_load, // Load the register address pointer
	input wire [6:0] addr_in, // Address to load
	input wire reg_wr, // Register write strobe
	input wire reg_rd, // Register read strobe
	input wire [7:0] reg_wdata, // Register write data
	output wire [7:0] reg_rdata, // Register read data
	output wire [6:0] addr_ptr, // Current register address
	input wire stream_en, // Transmitter drains the buffer
	output wire tx_valid, // Stream byte available
	input wire tx_ready, // Transmitter takes the byte
	output wire [7:0] tx_data, // Stream byte
	input wire [2:0] event_clear, // Clears error, near-empty, near-full
	output wire near_full_flag, // Live near-full level
	output wire near_empty_flag, // Live near-empty level
	output wire near_full_event, // Sticky near-full rise
	output wire near_empty_event, // Sticky near-empty rise
	output wire general_error_event, // Sticky error event
	output wire buffer_write_error, // Sticky write-while-streaming
	output wire buffer_overflow_error // Sticky write-while-full
);

	// Main byte store
	reg [7:0] mem [0:BUF_DEPTH-1];
	reg [BUF_AW-1:0] wr_ptr_ff;
	reg [BUF_AW-1:0] rd_ptr_ff;
	reg [CNT_W-1:0] fill_count_ff;
	reg [CNT_W-1:0] nxt_fill_count;
	reg [BUF_AW-1:0] nxt_wr_ptr;
	reg [BUF_AW-1:0] nxt_rd_ptr;

	// Host visible control state
	reg buffer_depth_select_ff;
	reg [7:0] threshold_low_ff;
	reg threshold_msb_ff;
	reg [6:0] addr_ptr_ff;
	reg [7:0] reg_rdata_ff;
	reg [6:0] nxt_addr_ptr;
	reg [7:0] nxt_reg_rdata;

	// Event and error state
	reg near_full_prev_ff;
	reg near_empty_prev_ff;
	reg near_full_event_ff;
	reg near_empty_event_ff;
	reg general_error_event_ff;
	reg buffer_write_error_ff;
	reg buffer_overflow_error_ff;

	wire [CNT_W-1:0] depth_bytes;
	wire [CNT_W-1:0] threshold;
	wire [CNT_W-1:0] room_left;
	wire buf_full;
	wire buf_empty;
	wire port_sel;
	wire port_wr;
	wire port_rd;
	wire ctrl_wr;
	wire clear_req;
	wire host_push;
	wire host_pop;
	wire move_pop;
	wire any_pop;
	wire wr_err_hit;
	wire ovf_hit;
	wire stage_ready;
	wire [7:0] head_byte;
	wire [1:0] count_msbs;
	wire [7:0] ctrl_read;
	wire near_full_rise;
	wire near_empty_rise;

	// Depth from the select bit
	assign depth_bytes = buffer_depth_select_ff ?
		`DEPTH_SMALL : `DEPTH_LARGE;

	// Extension threshold bit only counts in large mode
	assign threshold = {1'b0,
		threshold_msb_ff & ~buffer_depth_select_ff,
		threshold_low_ff};

	assign buf_full = (fill_count_ff >= depth_bytes);
	assign buf_empty = (fill_count_ff == `RST_FILL_COUNT);
	assign room_left = depth_bytes - fill_count_ff;

	// Live alert levels
	assign near_full_flag = buf_full |
		(room_left <= threshold);
	assign near_empty_flag = (fill_count_ff <= threshold);

	// Access decode at the current pointer
	assign port_sel = (addr_ptr_ff == `OFF_BUFFER_DATA_PORT);
	assign port_wr = reg_wr & port_sel;
	assign port_rd = reg_rd & ~reg_wr & port_sel;
	assign ctrl_wr = reg_wr &
		(addr_ptr_ff == `OFF_BUFFER_CONTROL_STATUS);
	assign clear_req = ctrl_wr & reg_wdata[`BIT_BUFFER_CLEAR];

	// Push and pop qualification
	assign wr_err_hit = port_wr & stream_en & ~clear_req;
	assign ovf_hit = port_wr & ~stream_en & buf_full &
		~clear_req;
	assign host_push = port_wr & ~stream_en & ~buf_full &
		~clear_req;
	assign host_pop = port_rd & ~buf_empty & ~clear_req;
	assign move_pop = stream_en & ~buf_empty & ~host_pop &
		stage_ready & ~clear_req;
	assign any_pop = host_pop | move_pop;
	assign head_byte = mem[rd_ptr_ff];

	// Count extension shown only in large mode
	assign count_msbs = buffer_depth_select_ff ? 2'h0 :
		fill_count_ff[9:8];

	// Control register read image, clear bit always zero
	assign ctrl_read = {buffer_depth_select_ff,
		near_full_flag,
		near_empty_flag,
		1'b0,
		1'b0,
		threshold_msb_ff & ~buffer_depth_select_ff,
		count_msbs};

	assign reg_rdata = reg_rdata_ff;
	assign addr_ptr = addr_ptr_ff;
	assign near_full_event = near_full_event_ff;
	assign near_empty_event = near_empty_event_ff;
	assign general_error_event = general_error_event_ff;
	assign buffer_write_error = buffer_write_error_ff;
	assign buffer_overflow_error = buffer_overflow_error_ff;

	// Next fill count
	always @* begin
		nxt_fill_count = fill_count_ff;
		if (clear_req) begin
			nxt_fill_count = `RST_FILL_COUNT;
		end else if (host_push && !any_pop) begin
			nxt_fill_count = fill_count_ff + 1'b1;
		end else if (any_pop && !host_push) begin
			nxt_fill_count = fill_count_ff - 1'b1;
		end
	end

	// Byte store write, no reset needed on data
	always @(posedge sys_clk) begin
		if (host_push) begin
			mem[wr_ptr_ff] <= reg_wdata;
		end
	end

	// Next store pointers, both rewound by a clear
	always @* begin
		nxt_wr_ptr = wr_ptr_ff;
		nxt_rd_ptr = rd_ptr_ff;
		if (clear_req) begin
			nxt_wr_ptr = {BUF_AW{1'b0}};
			nxt_rd_ptr = {BUF_AW{1'b0}};
		end else begin
			if (host_push) begin
				nxt_wr_ptr = wr_ptr_ff + 1'b1;
			end
			if (any_pop) begin
				nxt_rd_ptr = rd_ptr_ff + 1'b1;
			end
		end
	end

	// Pointers and fill count
	always @(posedge sys_clk) begin
		if (rst) begin
			wr_ptr_ff <= {BUF_AW{1'b0}};
			rd_ptr_ff <= {BUF_AW{1'b0}};
			fill_count_ff <= `RST_FILL_COUNT;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			fill_count_ff <= nxt_fill_count;
		end
	end

	// Control and threshold registers
	always @(posedge sys_clk) begin
		if (rst) begin
			buffer_depth_select_ff <= `RST_DEPTH_SELECT;
			threshold_msb_ff <= `RST_THRESHOLD_MSB;
			threshold_low_ff <= `RST_THRESHOLD_LOW;
		end else begin
			if (ctrl_wr) begin
				// Host clears first before changing depth
				buffer_depth_select_ff <=
					reg_wdata[`BIT_DEPTH_SELECT];
				threshold_msb_ff <=
					reg_wdata[`BIT_THRESHOLD_MSB];
			end
			if (reg_wr && addr_ptr_ff == `OFF_ALERT_THRESHOLD) begin
				threshold_low_ff <= reg_wdata;
			end
		end
	end

	// Next address pointer, held on data port accesses
	always @* begin
		nxt_addr_ptr = addr_ptr_ff;
		if (addr_load) begin
			nxt_addr_ptr = addr_in;
		end else if ((reg_wr || reg_rd) && !port_sel) begin
			nxt_addr_ptr = addr_ptr_ff + 1'b1;
		end
	end

	// Address pointer register
	always @(posedge sys_clk) begin
		if (rst) begin
			addr_ptr_ff <= `RST_ADDR_PTR;
		end else begin
			addr_ptr_ff <= nxt_addr_ptr;
		end
	end

	// Read data selection at the current pointer
	always @* begin
		nxt_reg_rdata = reg_rdata_ff;
		if (reg_rd && !reg_wr) begin
			if (addr_ptr_ff == `OFF_BUFFER_CONTROL_STATUS) begin
				nxt_reg_rdata = ctrl_read;
			end else if (addr_ptr_ff == `OFF_ALERT_THRESHOLD) begin
				nxt_reg_rdata = threshold_low_ff;
			end else if (addr_ptr_ff == `OFF_STORED_BYTE_COUNT) begin
				nxt_reg_rdata = fill_count_ff[7:0];
			end else if (port_sel) begin
				nxt_reg_rdata = host_pop ? head_byte :
					`EMPTY_READ_DATA;
			end else begin
				nxt_reg_rdata = `UNMAPPED_READ_DATA;
			end
		end
	end

	// Read data register, holds until the next read
	always @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata_ff <= `RST_READ_DATA;
		end else begin
			reg_rdata_ff <= nxt_reg_rdata;
		end
	end

	// Flag levels one cycle back, reset to their idle levels
	always @(posedge sys_clk) begin
		if (rst) begin
			near_full_prev_ff <= 1'b0;
			near_empty_prev_ff <= 1'b1;
		end else begin
			near_full_prev_ff <= near_full_flag;
			near_empty_prev_ff <= near_empty_flag;
		end
	end

	// Rises of the live alert levels
	assign near_full_rise = near_full_flag & ~near_full_prev_ff;
	assign near_empty_rise = near_empty_flag & ~near_empty_prev_ff;

	// Sticky alert events, set beats clear
	always @(posedge sys_clk) begin
		if (rst) begin
			near_full_event_ff <= 1'b0;
			near_empty_event_ff <= 1'b0;
		end else begin
			if (near_full_rise)
				near_full_event_ff <= 1'b1;
			else if (event_clear[0])
				near_full_event_ff <= 1'b0;
			if (near_empty_rise)
				near_empty_event_ff <= 1'b1;
			else if (event_clear[1])
				near_empty_event_ff <= 1'b0;
		end
	end

	// Sticky error flags and general error event
	always @(posedge sys_clk) begin
		if (rst) begin
			buffer_write_error_ff <= 1'b0;
			buffer_overflow_error_ff <= 1'b0;
			general_error_event_ff <= 1'b0;
		end else begin
			if (wr_err_hit)
				buffer_write_error_ff <= 1'b1;
			else if (event_clear[2])
				buffer_write_error_ff <= 1'b0;
			if (ovf_hit)
				buffer_overflow_error_ff <= 1'b1;
			else if (event_clear[2])
				buffer_overflow_error_ff <= 1'b0;
			if (wr_err_hit || ovf_hit)
				general_error_event_ff <= 1'b1;
			else if (event_clear[2])
				general_error_event_ff <= 1'b0;
		end
	end

	// Staging fifo toward the transmitter, stalls the mover
	byte_stream_fifo #(
		.WIDTH(8),
		.DEPTH(STAGE_DEPTH),
		.AW(STAGE_AW)
	) u_stage (
		.sys_clk(sys_clk),
		.rst(rst),
		.flush(clear_req),
		.in_valid(move_pop),
		.in_ready(stage_ready),
		.in_data(head_byte),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(tx_data)
	);

endmodule

// >>> host_data_fifo_defs.vh
`ifndef HOST_DATA_FIFO_DEFS_VH
`define HOST_DATA_FIFO_DEFS_VH

// Register offsets on the host register port
`define OFF_BUFFER_CONTROL_STATUS 7'h02
`define OFF_ALERT_THRESHOLD 7'h03
`define OFF_STORED_BYTE_COUNT 7'h04
`define OFF_BUFFER_DATA_PORT 7'h05

// Field positions in buffer_control_status
`define BIT_DEPTH_SELECT 7
`define BIT_NEAR_FULL 6
`define BIT_NEAR_EMPTY 5
`define BIT_BUFFER_CLEAR 4
`define BIT_THRESHOLD_MSB 2
`define BIT_COUNT_MSB_HI 1
`define BIT_COUNT_MSB_LO 0

// Reset values
`define RST_DEPTH_SELECT 1'b0
`define RST_THRESHOLD_LOW 8'h00
`define RST_THRESHOLD_MSB 1'b0
`define RST_FILL_COUNT 10'h000
`define RST_ADDR_PTR 7'h00

// Selectable buffer depths in bytes
`define DEPTH_SMALL 10'h0ff
`define DEPTH_LARGE 10'h200

// Answer of a data port read on an empty buffer
`define EMPTY_READ_DATA 8'h00

// Read data after reset and from unmapped addresses
`define RST_READ_DATA 8'h00
`define UNMAPPED_READ_DATA 8'h00

`endif

// >>> byte_stream_fifo.v
`timescale 1ns/1ps
module byte_stream_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire sys_clk, // System clock
	input wire rst, // Synchronous reset, active high
	input wire flush, // Empties the fifo
	input wire in_valid, // Word offered
	output wire in_ready, // Room for a word
	input wire [WIDTH-1:0] in_data, // Word in
	output wire out_valid, // Word available
	input wire out_ready, // Consumer takes the word
	output wire [WIDTH-1:0] out_data // Oldest word
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_ff;
	reg [AW-1:0] rd_ptr_ff;
	reg [AW:0] count_ff;
	wire do_push;
	wire do_pop;

	// Honest full and empty from the occupancy count
	assign in_ready = (count_ff != DEPTH[AW:0]);
	assign out_valid = (count_ff != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr_ff];
	assign do_push = in_valid & in_ready;
	assign do_pop = out_valid & out_ready;

	// Storage write
	always @(posedge sys_clk) begin
		if (do_push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end

	// Pointers and count, wrapping at DEPTH
	always @(posedge sys_clk) begin
		if (rst || flush) begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			count_ff <= {(AW+1){1'b0}};
		end else begin
			if (do_push) begin
				if (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1)
					wr_ptr_ff <= {AW{1'b0}};
				else
					wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (do_pop) begin
				if (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1)
					rd_ptr_ff <= {AW{1'b0}};
				else
					rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
			if (do_push && !do_pop)
				count_ff <= count_ff + 1'b1;
			else if (do_pop && !do_push)
				count_ff <= count_ff - 1'b1;
		end
	end

endmodule

// >>> host_data_fifo_control_chk.sv
`timescale 1ns/1ps
`include "host_data_fifo_defs.vh"
module host_data_fifo_control_chk (
	input wire sys_clk, // System clock
	input wire rst, // Synchronous reset
	input wire addr_load, // Pointer load
	input wire reg_wr, // Write strobe
	input wire reg_rd, // Read strobe
	input wire [6:0] addr_ptr, // Register pointer
	input wire [7:0] reg_rdata, // Read data
	input wire [2:0] event_clear, // Event clears
	input wire near_full_flag, // Live near-full
	input wire near_empty_flag, // Live near-empty
	input wire near_full_event, // Sticky near-full
	input wire near_empty_event, // Sticky near-empty
	input wire general_error_event, // General error
	input wire buffer_overflow_error // Overflow error
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_ptr_hold;
		(reg_wr || reg_rd) && !addr_load &&
			addr_ptr == `OFF_BUFFER_DATA_PORT
			|=> addr_ptr == `OFF_BUFFER_DATA_PORT;
	endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved");
	property p_ptr_inc;
		(reg_wr || reg_rd) && !addr_load &&
			addr_ptr != `OFF_BUFFER_DATA_PORT
			|=> addr_ptr == $past(addr_ptr) + 7'h01;
	endproperty
	a_ptr_inc: assert property (p_ptr_inc) else $error("pointer stuck");
	property p_nf_event;
		$rose(near_full_flag) |=> near_full_event;
	endproperty
	a_nf_event: assert property (p_nf_event) else $error("full event lost");
	property p_ne_event;
		$rose(near_empty_flag) |=> near_empty_event;
	endproperty
	a_ne_event: assert property (p_ne_event) else $error("empty event lost");
	property p_nf_sticky;
		near_full_event && !event_clear[0] |=> near_full_event;
	endproperty
	a_nf_sticky: assert property (p_nf_sticky) else $error("event dropped");
	property p_err;
		$rose(buffer_overflow_error) |-> ##[0:1] general_error_event;
	endproperty
	a_err: assert property (p_err) else $error("error event lost");
	property p_rst_flags;
		$fell(rst) |-> near_empty_flag && !near_full_flag;
	endproperty
	a_rst_flags: assert property (p_rst_flags) else $error("reset flags");
	property p_rd_hold;
		!reg_rd |=> $stable(reg_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule

bind host_data_fifo_control host_data_fifo_control_chk u_chk (.*);

// >>> tx_sink.sv
`timescale 1ns/1ps
module tx_sink (
	input wire sys_clk, // System clock
	input wire slow, // Random stalls when high
	output reg tx_ready // Takes the offered byte
);
	integer seed = 32'h1c21;
	initial tx_ready = 1'b0;
	// Ready moves just after each edge
	always @(posedge sys_clk) begin
		#1;
		tx_ready = slow ? ($random(seed) % 4 == 0) : 1'b1;
	end
endmodule

// >>> host_data_fifo_control_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
$display("Error t=%0t got %h exp %h", $time, g, e); end end
module host_data_fifo_control_tb_top;
	reg sys_clk = 0, rst = 1, addr_load = 0, reg_wr = 0, reg_rd = 0;
	reg stream_en = 0, slow = 0, sel = 0, tm = 0, rd_seen = 0;
	reg [6:0] addr_in = 0;
	reg [7:0] reg_wdata = 0, b, tl = 0, got_e;
	reg [2:0] event_clear = 0;
	wire [7:0] reg_rdata, tx_data;
	wire [6:0] addr_ptr;
	wire tx_valid, tx_ready, near_full_flag, near_empty_flag, near_full_event;
	wire near_empty_event, general_error_event, buffer_write_error;
	wire buffer_overflow_error;
	integer seed = 32'h1c21, n_fail = 0, samples_checked = 0, i;
	reg [7:0] exp_q[$], m[$], tx_q[$];
	always #2.5 sys_clk = ~sys_clk;
	host_data_fifo_control DUT (.*);
	tx_sink sink (.*);
	// Notes compared as reads and stream bytes appear
	always @(negedge sys_clk) begin
		if (rd_seen) begin
			got_e = exp_q.pop_front();
			`CHK(reg_rdata, got_e)
		end
		if (tx_valid && tx_ready) begin
			got_e = tx_q.pop_front();
			`CHK(tx_data, got_e)
		end
	end
	always @(posedge sys_clk) rd_seen <= reg_rd && !reg_wr && !rst;
	task acc(input l, w, r, input [7:0] v, e);
	begin
		@(posedge sys_clk);
		#1;
		addr_load = l;
		addr_in = v[6:0];
		reg_wr = w;
		reg_rd = r;
		reg_wdata = v;
		if (r) exp_q.push_back(e);
	end
	endtask
	task fill(input integer n);
		repeat (n) begin
			b = $random(seed);
			acc(0, 1, 0, b, 0);
			if (m.size() < (sel ? 255 : 512)) m.push_back(b);
		end
	endtask
	// Expected control byte from the model
	function [7:0] ctl();
		reg [9:0] c, t, d;
		c = m.size();
		d = sel ? 10'h0ff : 10'h200;
		t = {1'b0, !sel & tm, tl};
		ctl = {sel, d - c <= t, c <= t, 2'b00, !sel & tm, sel ? 2'b00 : c[9:8]};
	endfunction
	task summarize;
	begin
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	initial begin
		#300000;
		n_fail++;
		summarize;
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		#1 rst = 0;
		// Reset values, pointer walk, empty read
		acc(1, 0, 0, 8'h02, 0);
		acc(0, 0, 1, 0, 8'h20);
		acc(0, 0, 1, 0, 8'h00);
		acc(0, 0, 1, 0, 8'h00);
		acc(0, 0, 1, 0, 8'h00);
		fill(20);
		acc(1, 0, 0, 8'h04, 0);
		acc(0, 0, 1, 0, 8'h14);
		acc(1, 0, 0, 8'h05, 0);
		while (m.size()) acc(0, 0, 1, 0, m.pop_front());
		// Threshold against rising count
		acc(1, 0, 0, 8'h03, 0);
		`CHK(addr_ptr, 7'h05)
		acc(0, 1, 0, 8'h03, 0);
		tl = 3;
		for (i = 0; i < 6; i++) begin
			acc(1, 0, 0, 8'h02, 0);
			acc(0, 0, 1, 0, ctl());
			b = ctl();
			`CHK({near_full_flag, near_empty_flag}, b[6:5])
			acc(1, 0, 0, 8'h05, 0);
			fill(1);
		end
		// Clear, then 255 mode filled past full
		acc(1, 0, 0, 8'h02, 0);
		acc(0, 1, 0, 8'h10, 0);
		m = {};
		acc(1, 0, 0, 8'h02, 0);
		acc(0, 1, 0, 8'h84, 0);
		acc(0, 1, 0, 8'h00, 0);
		{sel, tm, tl} = {2'b11, 8'h00};
		acc(1, 0, 0, 8'h05, 0);
		fill(256);
		acc(1, 0, 0, 8'h02, 0);
		acc(0, 0, 1, 0, ctl());
		acc(0, 0, 0, 0, 0);
		`CHK(buffer_overflow_error, 1'b1)
		`CHK(general_error_event, 1'b1)
		`CHK(near_full_event, 1'b1)
		`CHK(near_empty_event, 1'b1)
		event_clear = 3'h7;
		@(posedge sys_clk) #1 event_clear = 3'h0;
		`CHK(general_error_event, 1'b0)
		`CHK(near_full_event, 1'b0)
		// 512 mode with wide threshold and count
		acc(1, 0, 0, 8'h02, 0);
		acc(0, 1, 0, 8'h90, 0);
		m = {};
		acc(1, 0, 0, 8'h02, 0);
		acc(0, 1, 0, 8'h04, 0);
		acc(0, 1, 0, 8'h30, 0);
		{sel, tm, tl} = {2'b01, 8'h30};
		acc(1, 0, 0, 8'h05, 0);
		fill(300);
		acc(1, 0, 0, 8'h02, 0);
		acc(0, 0, 1, 0, ctl());
		acc(0, 0, 0, 0, 0);
		// Drain to a stalling transmitter, write while streaming
		slow = 1;
		tx_q = m;
		m = {};
		stream_en = 1;
		for (i = 0; i < 20000 && tx_q.size(); i++) @(posedge sys_clk);
		`CHK(tx_q.size(), 0)
		acc(1, 0, 0, 8'h05, 0);
		acc(0, 1, 0, 8'h5a, 0);
		acc(1, 0, 0, 8'h04, 0);
		acc(0, 0, 1, 0, 8'h00);
		acc(0, 0, 0, 0, 0);
		`CHK(buffer_write_error, 1'b1)
		stream_en = 0;
		repeat (2) @(posedge sys_clk);
		summarize;
	end
endmodule
